//--- tb/ext_io_model.sv
// input equipment on channels 1, 3, 5, 7 holding each word until taken
`timescale 1ns/1ns
module ext_io_model (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// bench commands
	input  wire logic        req,
	input  wire logic [1:0]  req_ch,
	input  wire logic [14:0] req_addr,
	input  wire logic [47:0] req_word,
	// channel side
	input  wire logic [3:0]  in_taken_r,
	output logic [3:0]       in_valid,
	output logic [14:0]      in_addr [4],
	output logic [47:0]      in_word [4]
);
	initial begin
		in_valid = 4'h0;
		in_addr = '{default: 15'h0000};
		in_word = '{default: 48'h0};
	end
	always @(posedge core_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (!nrst || in_taken_r[i]) begin
				// released lines flip so a stale word cannot pass
				in_valid[i] <= 1'b0;
				in_addr[i] <= ~in_addr[i];
				in_word[i] <= ~in_word[i];
			end else if (req && req_ch == 2'(i)) begin
				in_valid[i] <= 1'b1;
				in_addr[i] <= req_addr;
				in_word[i] <= req_word;
			end
		end
	end
endmodule

//--- tb/ics_props.sv
// assertions on the store exchange ports
`timescale 1ns/1ns
module ics_props (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        prog_taken_r,
	input wire logic        prog_rvalid_r,
	input wire logic [3:0]  in_taken_r,
	input wire logic        con_valid,
	input wire logic        con_taken_r,
	input wire logic [3:0]  out_valid_r,
	input wire logic        ctl_load,
	input wire logic [47:0] ctl_data,
	input wire logic        ctl_strobe_r,
	input wire logic [47:0] ctl_out_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence ctl_seq;
		ctl_strobe_r && ctl_out_r == $past(ctl_data);
	endsequence
	rst_clear_a: assert property (disable iff (1'b0) !nrst |=> !prog_taken_r && out_valid_r == 4'h0
		&& ctl_out_r == 48'h0) else $error("outputs not cleared by reset");
	ctl_load_a: assert property (ctl_load |=> ctl_seq) else $error("control word not loaded");
	ctl_hold_a: assert property (!ctl_load |=> !ctl_strobe_r && $stable(ctl_out_r))
		else $error("control output moved without load");
	one_take_a: assert property ($onehot0({prog_taken_r, con_taken_r, in_taken_r}))
		else $error("two requests taken at once");
	rd_lat_a: assert property (prog_rvalid_r |-> $past(prog_taken_r, 552))
		else $error("read word late or early");
	out_lat_a: assert property (|out_valid_r |-> $past(prog_taken_r, 552))
		else $error("output word without timed read");
	out_one_a: assert property ($onehot0(out_valid_r)) else $error("two outputs at once");
	con_first_a: assert property (in_taken_r[0] |-> !$past(con_valid))
		else $error("channel 1 taken over console");
endmodule
bind interleaved_core_store_exchange ics_props i_props (.core_clk, .nrst, .prog_taken_r,
	.prog_rvalid_r, .in_taken_r, .con_valid, .con_taken_r, .out_valid_r, .ctl_load, .ctl_data,
	.ctl_strobe_r, .ctl_out_r);

//--- tb/tb_interleaved_core_store_exchange.sv
// self-checking bench for the interleaved core store exchange
`timescale 1ns/1ns
module tb_interleaved_core_store_exchange;
	typedef struct {
		logic [2:0]  dst;
		logic [47:0] w;
	} note_s;
	logic        core_clk = 1'b0, nrst = 1'b0;
	logic        prog_valid = 1'b0, prog_write = 1'b0;
	logic [14:0] prog_addr = 15'h0000, con_addr = 15'h0000, req_addr = 15'h0000, a, b;
	logic [47:0] prog_wdata = 48'h0, con_word = 48'h0, req_word = 48'h0, w0, w1;
	logic [2:0]  prog_dest = 3'h0;
	logic        prog_taken_r, prog_rvalid_r, con_taken_r, ctl_strobe_r;
	logic [47:0] prog_rdata_r, ctl_out_r, ctl_data = 48'h0;
	logic [3:0]  in_valid, in_taken_r, out_valid_r;
	logic [14:0] in_addr [4];
	logic [47:0] in_word [4], out_word_r [4];
	logic        con_valid = 1'b0, ctl_load = 1'b0, req = 1'b0;
	logic [1:0]  req_ch = 2'h0;
	note_s       notes [$];
	int          num_errors = 0, checks = 0, cyc = 0, t0, t1;

	interleaved_core_store_exchange i_dut (.core_clk, .nrst, .prog_valid, .prog_write,
		.prog_addr, .prog_wdata, .prog_dest, .prog_taken_r, .prog_rvalid_r, .prog_rdata_r,
		.in_valid, .in_addr, .in_word, .in_taken_r, .con_valid, .con_addr, .con_word,
		.con_taken_r, .out_valid_r, .out_word_r, .ctl_load, .ctl_data, .ctl_strobe_r, .ctl_out_r);
	ext_io_model i_io (.core_clk, .nrst, .req, .req_ch, .req_addr, .req_word, .in_taken_r,
		.in_valid, .in_addr, .in_word);

	always #2 core_clk = ~core_clk;

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(string what, logic [47:0] exp, logic [47:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [47:0] rnd();
		return 48'({$urandom(), $urandom()});
	endfunction

	task automatic prog_op(logic wr, logic [14:0] ad, logic [47:0] d, logic [2:0] dst,
		output int tk);
		@(posedge core_clk);
		prog_valid <= 1'b1;
		prog_write <= wr;
		prog_addr <= ad;
		prog_wdata <= d;
		prog_dest <= dst;
		repeat (4000) begin
			@(posedge core_clk);
			if (prog_taken_r === 1'b1)
				break;
		end
		check("request taken", 48'h1, {47'h0, prog_taken_r});
		prog_valid <= 1'b0;
		prog_wdata <= ~d;
		tk = int'($time / 4);
		if (!wr)
			notes.push_back('{dst, d});
	endtask

	task automatic take(logic [2:0] dst, logic [47:0] w);
		note_s n;
		if (notes.size() > 0)
			n = notes.pop_front();
		else
			n = '{3'h7, ~w};
		check("read destination", {45'h0, n.dst}, {45'h0, dst});
		check("read word", n.w, w);
	endtask

	// result watcher: each delivered word retires the oldest note
	always @(posedge core_clk) begin
		cyc++;
		if (prog_rvalid_r === 1'b1)
			take(3'h0, prog_rdata_r);
		for (int i = 0; i < 4; i++)
			if (out_valid_r[i] === 1'b1)
				take(3'(i + 1), out_word_r[i]);
		if (cyc == 40000) begin
			num_errors++;
			$display("Error run time expected under %0d cycles seen %0d", 40000, cyc);
			report_and_stop();
		end
	end

	initial begin
		void'($urandom(32'hFD59DEF8));
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		check("reset outputs", 48'h0, ctl_out_r | {40'h0, out_valid_r, in_taken_r});
		$display("test reset done");
		w0 = rnd();
		ctl_load <= 1'b1;
		ctl_data <= w0;
		@(posedge core_clk);
		ctl_load <= 1'b0;
		@(posedge core_clk);
		check("control output", w0, ctl_out_r);
		check("control strobe", 48'h1, {47'h0, ctl_strobe_r});
		$display("test control done");
		w0 = rnd();
		w1 = rnd();
		prog_op(1'b1, 15'h7FFE, w0, 3'h0, t0);
		prog_op(1'b1, 15'h7FFF, w1, 3'h0, t1);
		check("alternate bank gap", 48'(t1 - t0 <= 3), 48'h1);
		prog_op(1'b0, 15'h7FFE, w0, 3'h0, t1);
		check("same bank gap", 48'(t1 - t0 >= ics_pkg::CYCLE_CYC), 48'h1);
		for (int k = 1; k < 5; k++)
			prog_op(1'b0, 15'h7FFF, w1, 3'(k), t1);
		$display("test banks done");
		for (int k = 0; k < 4; k++) begin
			w0 = rnd();
			a = 15'($urandom());
			req <= 1'b1;
			req_ch <= 2'(k);
			req_addr <= a;
			req_word <= w0;
			@(posedge core_clk);
			req <= 1'b0;
			prog_op(1'b0, a, w0, 3'(k + 1), t1);
		end
		$display("test channels done");
		w0 = rnd();
		w1 = rnd();
		a = {14'($urandom()), 1'b0};
		b = {14'($urandom()), 1'b1};
		req <= 1'b1;
		req_ch <= 2'h0;
		req_addr <= b;
		req_word <= w1;
		con_valid <= 1'b1;
		con_addr <= a;
		con_word <= w0;
		@(posedge core_clk);
		req <= 1'b0;
		repeat (4000) begin
			if (con_taken_r === 1'b1)
				break;
			@(posedge core_clk);
		end
		check("console taken", 48'h1, {47'h0, con_taken_r});
		con_valid <= 1'b0;
		check("channel 1 waits", 48'h1, {47'h0, in_valid[0]});
		prog_op(1'b0, a, w0, 3'h0, t1);
		prog_op(1'b0, b, w1, 3'h0, t1);
		repeat (4000) begin
			@(posedge core_clk);
			if (notes.size() == 0)
				break;
		end
		check("pending reads", 48'h0, 48'(notes.size()));
		$display("test console done");
		report_and_stop();
	end
endmodule

//--- verilog/bank_if.sv
// link between storage control and one core bank
`timescale 1ns/1ns
interface bank_if #(
	parameter int W  = 48,
	parameter int AW = 14
);
	logic          start;
	logic          wr;
	logic [AW-1:0] addr;
	logic [W-1:0]  wdata;
	logic          busy;
	logic          rvalid;
	logic [W-1:0]  rdata;

	modport ctrl (output start, output wr, output addr, output wdata,
		input busy, input rvalid, input rdata);
	modport bank (input start, input wr, input addr, input wdata,
		output busy, output rvalid, output rdata);
endinterface

//--- verilog/core_bank.sv
// one core bank with its address and restoration registers
`timescale 1ns/1ns
module core_bank #(
	parameter int W      = ics_pkg::WORD_W,
	parameter int AW     = ics_pkg::BANK_AW,
	parameter int ACCESS = ics_pkg::ACCESS_CYC,
	parameter int CYCLE  = ics_pkg::CYCLE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// control side
	bank_if.bank     bp
);
	logic [W-1:0]               mem [0:(2**AW)-1];
	ics_pkg::bank_state_e       state_r, state_nxt;
	logic [ics_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;
	logic [AW-1:0]              s_r, s_nxt;
	logic [W-1:0]               z_r, z_nxt;
	logic                       wr_r, wr_nxt;
	logic                       rvalid;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		s_nxt     = s_r;
		z_nxt     = z_r;
		wr_nxt    = wr_r;
		rvalid    = 1'b0;
		case (state_r)
			ics_pkg::BK_IDLE: begin
				if (bp.start) begin
					s_nxt     = bp.addr; // see R6
					z_nxt     = bp.wdata; // see R9
					wr_nxt    = bp.wr;
					cnt_nxt   = '0;
					state_nxt = ics_pkg::BK_READ;
				end
			end
			ics_pkg::BK_READ: begin
				cnt_nxt = cnt_r + ics_pkg::CNT_W'(1);
				if (cnt_r == ics_pkg::CNT_W'(ACCESS - 1)) begin // see R3
					rvalid = ~wr_r;
					if (!wr_r)
						z_nxt = mem[s_r]; // see R7
					state_nxt = ics_pkg::BK_RESTORE;
				end
			end
			ics_pkg::BK_RESTORE: begin
				cnt_nxt = cnt_r + ics_pkg::CNT_W'(1);
				if (cnt_r == ics_pkg::CNT_W'(CYCLE - 1)) // see R4
					state_nxt = ics_pkg::BK_IDLE;
			end
			default: state_nxt = ics_pkg::BK_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_r <= ics_pkg::BK_IDLE;
			cnt_r   <= '0;
			s_r     <= '0;
			z_r     <= '0;
			wr_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			s_r     <= s_nxt;
			z_r     <= z_nxt;
			wr_r    <= wr_nxt;
		end
	end

	// restoration writes back at the end of every cycle
	always_ff @(posedge core_clk) begin
		if (state_r == ics_pkg::BK_RESTORE && cnt_r == ics_pkg::CNT_W'(CYCLE - 1))
			mem[s_r] <= z_r; // see R9
	end

	assign bp.busy   = (state_r != ics_pkg::BK_IDLE);
	assign bp.rvalid = rvalid;
	assign bp.rdata  = mem[s_r];
endmodule

//--- verilog/ics_pkg.sv
// constants and types shared by the interleaved core store exchange
package ics_pkg;
	localparam int WORD_W        = 48;
	localparam int ADDR_W        = 15;
	localparam int BANK_AW       = 14;
	localparam int N_BANK        = 2;
	localparam int N_IN          = 4;
	localparam int N_OUT         = 4;
	localparam int N_SRC         = N_IN + 1;
	localparam int SRC_PROG      = 4;
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_ACCESS_NS   = 2200;
	localparam int T_CYCLE_NS    = 6400;
	localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYCLE_CYC     = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 11;
	localparam int DEST_W        = 3;
	// lowest priority first: program, channels 5, 3, 1, then channel 7
	localparam int PRI_ORDER [N_SRC] = '{4, 2, 1, 0, 3};
	localparam logic [DEST_W-1:0] DEST_PROG = 3'h0;
	localparam logic [DEST_W-1:0] DEST_OUT1 = 3'h1;
	localparam logic [WORD_W-1:0] WORD_RST  = 48'h0;

	typedef enum logic [2:0] {
		BK_IDLE    = 3'b001,
		BK_READ    = 3'b010,
		BK_RESTORE = 3'b100
	} bank_state_e;
endpackage

//--- verilog/interleaved_core_store_exchange.sv
// storage control: two interleaved core banks, exchange register and i/o routing
// How it works
// R1 - 32768 words of 48 bits held as two banks of 16384 words.
// R2 - odd addresses go to one bank, even addresses to the other.
// R3 - read data comes 2.2 us after access starts; next step follows at once.
// R4 - a bank starts no new cycle before its 6.4 us cycle ends.
// R5 - banks run overlapped, alternating references complete every 3.2 us.
// R6 - each bank has its own address register loaded with the location.
// R7 - each bank has a restoration register holding the word written back.
// R8 - read words land in the exchange register, then go to their destination.
// R9 - stored words go exchange register to restoration register to bank.
// R10 - four 48-bit input channels enter storage through the exchange register.
// R11 - channels 1, 3, 5 are buffer inputs; channel 7 is high-speed transfer.
// R12 - console input always arrives over input channel 1.
// R13 - read words load four output registers feeding channels 2, 4, 6, 7.
// R14 - control words for external equipment use a separate control register.
// R15 - low address bit picks the bank, upper fourteen bits the word.
`timescale 1ns/1ns
module interleaved_core_store_exchange #(
	parameter int W  = ics_pkg::WORD_W,
	parameter int AW = ics_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       nrst,
	// program control request
	input  wire logic                       prog_valid,
	input  wire logic                       prog_write,
	input  wire logic [AW-1:0]              prog_addr,
	input  wire logic [W-1:0]               prog_wdata,
	input  wire logic [ics_pkg::DEST_W-1:0] prog_dest,
	output logic                            prog_taken_r,
	output logic                            prog_rvalid_r,
	output logic [W-1:0]                    prog_rdata_r,
	// input channels 1, 3, 5, 7
	input  wire logic [ics_pkg::N_IN-1:0]   in_valid,
	input  wire logic [AW-1:0]              in_addr [ics_pkg::N_IN],
	input  wire logic [W-1:0]               in_word [ics_pkg::N_IN],
	output logic [ics_pkg::N_IN-1:0]        in_taken_r,
	// console assembly word, carried on channel 1
	input  wire logic                       con_valid,
	input  wire logic [AW-1:0]              con_addr,
	input  wire logic [W-1:0]               con_word,
	output logic                            con_taken_r,
	// output channels 2, 4, 6, 7
	output logic [ics_pkg::N_OUT-1:0]       out_valid_r,
	output logic [W-1:0]                    out_word_r [ics_pkg::N_OUT],
	// control output to external equipment
	input  wire logic                       ctl_load,
	input  wire logic [W-1:0]               ctl_data,
	output logic                            ctl_strobe_r,
	output logic [W-1:0]                    ctl_out_r
);
	localparam int NS = ics_pkg::N_SRC;
	localparam int NB = ics_pkg::N_BANK;

	function automatic logic bank_of(input logic [AW-1:0] a);
		return a[0]; // see R2 R15
	endfunction

	bank_if #(.W(W), .AW(AW - 1)) bif [NB] ();

	logic [NB-1:0]               bk_busy, bk_rvalid;
	logic [W-1:0]                bk_rdata [NB];
	logic [NS-1:0]               src_v;
	logic [AW-1:0]               src_addr [NS];
	logic [W-1:0]                src_data [NS];
	logic [NS-1:0]               src_wr;
	logic                        ret_any, ret_bank;
	logic                        gnt_v, gnt_bank;
	logic [2:0]                  gnt_idx;
	logic                        con_sel;

	logic                        pend_v_r, pend_v_nxt;
	logic                        pend_bank_r, pend_bank_nxt;
	logic                        pend_wr_r, pend_wr_nxt;
	logic [AW-2:0]               pend_addr_r, pend_addr_nxt;
	logic [ics_pkg::DEST_W-1:0]  pend_dest_r, pend_dest_nxt;
	logic [ics_pkg::DEST_W-1:0]  dest_r [NB];
	logic [ics_pkg::DEST_W-1:0]  dest_nxt [NB];
	logic [W-1:0]                x_r, x_nxt;
	logic                        fwd_v_r, fwd_v_nxt;
	logic [ics_pkg::DEST_W-1:0]  fwd_dest_r, fwd_dest_nxt;
	logic [NS-1:0]               taken_r, taken_nxt;
	logic                        con_taken_nxt;
	logic                        prog_rvalid_nxt;
	logic [W-1:0]                prog_rdata_nxt;
	logic [ics_pkg::N_OUT-1:0]   out_valid_nxt;
	logic [W-1:0]                out_word_nxt [ics_pkg::N_OUT];
	logic                        ctl_strobe_nxt;
	logic [W-1:0]                ctl_out_nxt;

	genvar g;
	generate
		for (g = 0; g < NB; g++) begin : g_bank
			assign bif[g].start = pend_v_r && (pend_bank_r == 1'(g));
			assign bif[g].wr    = pend_wr_r;
			assign bif[g].addr  = pend_addr_r; // see R15
			assign bif[g].wdata = x_r; // see R9
			assign bk_busy[g]   = bif[g].busy;
			assign bk_rvalid[g] = bif[g].rvalid;
			assign bk_rdata[g]  = bif[g].rdata;
			core_bank #(.W(W), .AW(AW - 1)) u_bank ( // see R1
				.core_clk (core_clk),
				.nrst     (nrst),
				.bp       (bif[g])
			);
		end
	endgenerate

	// request sources: input channels first, program last
	always_comb begin
		con_sel = con_valid; // see R12
		for (int i = 0; i < ics_pkg::N_IN; i++) begin
			src_v[i]    = in_valid[i] & ~taken_r[i];
			src_addr[i] = in_addr[i];
			src_data[i] = in_word[i]; // see R10
			src_wr[i]   = 1'b1;
		end
		if (con_sel) begin
			src_v[0]    = ~con_taken_r;
			src_addr[0] = con_addr;
			src_data[0] = con_word;
		end
		src_v[ics_pkg::SRC_PROG]    = prog_valid & ~prog_taken_r;
		src_addr[ics_pkg::SRC_PROG] = prog_addr;
		src_data[ics_pkg::SRC_PROG] = prog_wdata;
		src_wr[ics_pkg::SRC_PROG]   = prog_write;
	end

	// grant: channel 7 highest, then 1, 3, 5, program last
	always_comb begin
		int idx;
		logic b;
		idx      = 0;
		b        = 1'b0;
		ret_any  = |bk_rvalid;
		ret_bank = bk_rvalid[1];
		gnt_v    = 1'b0;
		gnt_idx  = '0;
		gnt_bank = 1'b0;
		for (int k = 0; k < NS; k++) begin
			idx = ics_pkg::PRI_ORDER[k]; // see R11
			b   = bank_of(src_addr[idx]);
			// other bank may start while this one is busy: see R5
			if (src_v[idx] && !bk_busy[b] && !(pend_v_r && pend_bank_r == b) // see R4
				&& !ret_any) begin
				gnt_v    = 1'b1;
				gnt_idx  = 3'(idx);
				gnt_bank = b;
			end
		end
	end

	always_comb begin
		pend_v_nxt    = gnt_v;
		pend_bank_nxt = gnt_bank;
		pend_wr_nxt   = src_wr[gnt_idx];
		pend_addr_nxt = src_addr[gnt_idx][AW-1:1];
		pend_dest_nxt = (gnt_idx == 3'(ics_pkg::SRC_PROG)) ? prog_dest : ics_pkg::DEST_PROG;
		taken_nxt     = '0;
		con_taken_nxt = 1'b0;
		if (gnt_v) begin
			if (gnt_idx == 3'h0 && con_sel)
				con_taken_nxt = 1'b1;
			else
				taken_nxt[gnt_idx] = 1'b1;
		end
		for (int b = 0; b < NB; b++)
			dest_nxt[b] = (pend_v_r && pend_bank_r == 1'(b)) ? pend_dest_r : dest_r[b];
		x_nxt        = x_r;
		fwd_v_nxt    = ret_any;
		fwd_dest_nxt = dest_r[ret_bank];
		if (ret_any)
			x_nxt = bk_rdata[ret_bank]; // see R8
		else if (gnt_v && src_wr[gnt_idx])
			x_nxt = src_data[gnt_idx]; // see R9 R10
	end

	// forward from the exchange register to the destination
	always_comb begin
		prog_rvalid_nxt = 1'b0;
		prog_rdata_nxt  = prog_rdata_r;
		out_valid_nxt   = '0;
		for (int k = 0; k < ics_pkg::N_OUT; k++)
			out_word_nxt[k] = out_word_r[k];
		if (fwd_v_r) begin
			if (fwd_dest_r == ics_pkg::DEST_PROG) begin
				prog_rvalid_nxt = 1'b1;
				prog_rdata_nxt  = x_r; // see R8
			end else begin
				for (int k = 0; k < ics_pkg::N_OUT; k++) begin
					if (fwd_dest_r == ics_pkg::DEST_OUT1 + ics_pkg::DEST_W'(k)) begin
						out_valid_nxt[k] = 1'b1;
						out_word_nxt[k]  = x_r; // see R13
					end
				end
			end
		end
		ctl_strobe_nxt = ctl_load;
		ctl_out_nxt    = ctl_load ? ctl_data : ctl_out_r; // see R14
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pend_v_r      <= 1'b0;
			pend_bank_r   <= 1'b0;
			pend_wr_r     <= 1'b0;
			pend_addr_r   <= '0;
			pend_dest_r   <= ics_pkg::DEST_PROG;
			dest_r        <= '{default: ics_pkg::DEST_PROG};
			x_r           <= ics_pkg::WORD_RST;
			fwd_v_r       <= 1'b0;
			fwd_dest_r    <= ics_pkg::DEST_PROG;
			taken_r       <= '0;
			con_taken_r   <= 1'b0;
			prog_rvalid_r <= 1'b0;
			prog_rdata_r  <= ics_pkg::WORD_RST;
			out_valid_r   <= '0;
			out_word_r    <= '{default: ics_pkg::WORD_RST};
			ctl_strobe_r  <= 1'b0;
			ctl_out_r     <= ics_pkg::WORD_RST;
		end else begin
			pend_v_r      <= pend_v_nxt;
			pend_bank_r   <= pend_bank_nxt;
			pend_wr_r     <= pend_wr_nxt;
			pend_addr_r   <= pend_addr_nxt;
			pend_dest_r   <= pend_dest_nxt;
			dest_r        <= dest_nxt;
			x_r           <= x_nxt;
			fwd_v_r       <= fwd_v_nxt;
			fwd_dest_r    <= fwd_dest_nxt;
			taken_r       <= taken_nxt;
			con_taken_r   <= con_taken_nxt;
			prog_rvalid_r <= prog_rvalid_nxt;
			prog_rdata_r  <= prog_rdata_nxt;
			out_valid_r   <= out_valid_nxt;
			out_word_r    <= out_word_nxt;
			ctl_strobe_r  <= ctl_strobe_nxt;
			ctl_out_r     <= ctl_out_nxt;
		end
	end

	assign prog_taken_r = taken_r[ics_pkg::SRC_PROG];
	assign in_taken_r   = taken_r[ics_pkg::N_IN-1:0];
endmodule
